// ### hdl/sfe_front_end.sv
// Serial front end of a page-organised flash: framing, shifting, protection.
// Assumes serial pins are asynchronous to clk and the array accepts bytes by valid/ready.
`timescale 1ns/100ps
module sfe_front_end
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   output logic so,
   output logic so_oe,
   input wire logic wp_n,
   input wire logic reset_n,
   input wire logic page_alt,
   input wire logic [15:0] prot_sw,
   input wire logic prot_sw_en,
   output logic [7:0] cmd_opcode,
   output logic [23:0] cmd_addr,
   output logic cmd_start,
   output logic [7:0] wr_data,
   output logic wr_valid,
   input wire logic wr_ready,
   input wire logic [7:0] rd_data,
   output logic rd_take,
   output logic busy,
   output logic standby,
   output logic cmd_refused,
   output logic [15:0] prot_table,
   output logic [9:0] page_len,
   output logic overrun
);

   // ------------------------------------------------------------
   // Pin synchronisers and state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] cs_s;
      logic [1:0] sck_s;
      logic [1:0] si_s;
      logic [1:0] wp_s;
      logic [1:0] rn_s;
      logic sck_l;
      logic cs_l;
      sfe_pkg::sfe_state_t st;
      logic [2:0] bit_cnt;
      logic [1:0] addr_cnt;
      logic [7:0] shift;
      logic [7:0] op;
      logic [23:0] addr;
      logic [7:0] tx;
      logic wp_latch;
      logic [15:0] prot;
      logic [15:0] busy_cnt;
      logic so;
      logic so_oe;
      logic cmd_start;
      logic push;
      logic [7:0] push_data;
      logic rd_take;
      logic refused;
      logic overrun;
      logic [9:0] plen;
      logic busy;
      logic stby;
   } sfe_core_t;

   sfe_core_t s_q, s_d;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [7:0] buf_out_data;

   sfe_buf2 u_buf
   (
      .clk(clk),
      .rst(rst),
      .in_valid(s_q.push),
      .in_ready(buf_in_ready),
      .in_data(s_q.push_data),
      .out_valid(buf_out_valid),
      .out_ready(wr_ready),
      .out_data(buf_out_data)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic cs_fall;
      logic cs_rise;
      logic sck_rise;
      logic sck_fall;
      logic sel;
      logic wp_low;
      logic [7:0] nb;
      logic is_mod;
      logic sect_prot;
      cs_fall = 1'b0;
      cs_rise = 1'b0;
      sck_rise = 1'b0;
      sck_fall = 1'b0;
      sel = 1'b0;
      wp_low = 1'b0;
      nb = 8'h00;
      is_mod = 1'b0;
      sect_prot = 1'b0;
      s_d = s_q;
      s_d.cs_s = {s_q.cs_s[0], cs_n};
      s_d.sck_s = {s_q.sck_s[0], sck};
      s_d.si_s = {s_q.si_s[0], si};
      s_d.wp_s = {s_q.wp_s[0], wp_n};
      s_d.rn_s = {s_q.rn_s[0], reset_n};
      s_d.sck_l = s_q.sck_s[1];
      s_d.cs_l = s_q.cs_s[1];
      s_d.cmd_start = 1'b0;
      s_d.push = 1'b0;
      s_d.rd_take = 1'b0;
      sel = !s_q.cs_s[1];
      cs_fall = s_q.cs_l && !s_q.cs_s[1];
      cs_rise = !s_q.cs_l && s_q.cs_s[1];
      sck_rise = sel && !s_q.sck_l && s_q.sck_s[1];
      sck_fall = sel && s_q.sck_l && !s_q.sck_s[1];
      wp_low = !s_q.wp_s[1];
      s_d.plen = page_alt ? sfe_pkg::SFE_PAGE_ALT : sfe_pkg::SFE_PAGE_STD;
      if (wp_low)
      begin
         s_d.wp_latch = 1'b1;
      end
      else if (s_q.st == sfe_pkg::SFE_ST_IDLE)
      begin
         s_d.wp_latch = 1'b0;
      end
      nb = {s_q.shift[6:0], s_q.si_s[1]};
      is_mod = (s_q.op == sfe_pkg::SFE_OP_PROG) || (s_q.op == sfe_pkg::SFE_OP_ERASE);
      sect_prot = s_q.prot[s_q.addr[20:17]];
      if (s_q.busy_cnt != 16'h0000)
      begin
         s_d.busy_cnt = s_q.busy_cnt - 16'h0001;
      end
      if (sck_rise && s_q.st != sfe_pkg::SFE_ST_IDLE && s_q.st != sfe_pkg::SFE_ST_BUSY)
      begin
         s_d.shift = nb;
         s_d.bit_cnt = s_q.bit_cnt + 3'd1;
      end
      if (sck_fall && s_q.st != sfe_pkg::SFE_ST_IDLE)
      begin
         s_d.so = s_q.tx[7];
         s_d.tx = {s_q.tx[6:0], 1'b0};
      end
      case (s_q.st)
         sfe_pkg::SFE_ST_IDLE:
         begin
            if (cs_fall && s_q.busy_cnt == 16'h0000)
            begin
               s_d.st = sfe_pkg::SFE_ST_OPCODE;
               s_d.bit_cnt = 3'd0;
               s_d.addr_cnt = 2'd0;
               s_d.so_oe = 1'b1;
               s_d.refused = 1'b0;
            end
         end
         sfe_pkg::SFE_ST_OPCODE:
         begin
            if (sck_rise && s_q.bit_cnt == 3'd7)
            begin
               s_d.op = nb;
               s_d.tx = (nb == sfe_pkg::SFE_OP_STATUS) ? {s_q.busy_cnt == 16'h0000, 7'h00} : rd_data;
               s_d.st = sfe_pkg::SFE_ST_ADDR;
            end
         end
         sfe_pkg::SFE_ST_ADDR:
         begin
            if (sck_rise && s_q.bit_cnt == 3'd7)
            begin
               s_d.addr = {s_q.addr[15:0], nb};
               s_d.addr_cnt = s_q.addr_cnt + 2'd1;
               if (s_q.addr_cnt == 2'(sfe_pkg::SFE_ADDR_BYTES - 1))
               begin
                  s_d.st = sfe_pkg::SFE_ST_DATA;
                  if (s_q.op == sfe_pkg::SFE_OP_STATUS)
                  begin
                     s_d.tx = {s_q.busy_cnt == 16'h0000, 7'h00};
                  end
                  else
                  begin
                     s_d.tx = rd_data;
                     s_d.rd_take = 1'b1;
                  end
               end
            end
         end
         sfe_pkg::SFE_ST_DATA:
         begin
            if (s_q.op == sfe_pkg::SFE_OP_PROT_WR && s_q.wp_latch)
            begin
               s_d.st = sfe_pkg::SFE_ST_IGNORE;
               s_d.refused = 1'b1;
            end
            else if (is_mod && (sect_prot && (wp_low || prot_sw_en)))
            begin
               s_d.st = sfe_pkg::SFE_ST_IGNORE;
               s_d.refused = 1'b1;
            end
            else if (sck_rise && s_q.bit_cnt == 3'd7)
            begin
               if (s_q.op == sfe_pkg::SFE_OP_PROT_WR)
               begin
                  s_d.prot = {s_q.prot[7:0], nb};
               end
               else if (is_mod)
               begin
                  s_d.push = 1'b1;
                  s_d.push_data = nb;
                  s_d.overrun = s_q.overrun || !buf_in_ready;
               end
               s_d.tx = rd_data;
               s_d.rd_take = 1'b1;
            end
         end
         default:
         begin
            if (s_q.st == sfe_pkg::SFE_ST_BUSY && s_q.busy_cnt == 16'h0000)
            begin
               s_d.st = sfe_pkg::SFE_ST_IDLE;
            end
         end
      endcase
      if (cs_rise && s_q.st != sfe_pkg::SFE_ST_IDLE && s_q.st != sfe_pkg::SFE_ST_BUSY)
      begin
         s_d.so_oe = 1'b0;
         if (s_q.st == sfe_pkg::SFE_ST_DATA && is_mod)
         begin
            s_d.cmd_start = 1'b1;
            s_d.busy_cnt = 16'(sfe_pkg::SFE_BUSY_CYC - 1);
            s_d.st = sfe_pkg::SFE_ST_BUSY;
         end
         else
         begin
            s_d.st = sfe_pkg::SFE_ST_IDLE;
         end
      end
      if (rst || !s_q.rn_s[1])
      begin
         s_d.st = sfe_pkg::SFE_ST_IDLE;
         s_d.busy_cnt = 16'h0000;
         s_d.so_oe = 1'b0;
         s_d.so = 1'b0;
         s_d.push = 1'b0;
         s_d.cmd_start = 1'b0;
         s_d.rd_take = 1'b0;
         s_d.overrun = 1'b0;
      end
      if (rst)
      begin
         s_d = '0;
         s_d.cs_s = 2'b11;
         s_d.cs_l = 1'b1;
         // Chip select, write-protect and reset pins idle high, so their synchronisers start high and no false edge follows reset.
         s_d.wp_s = 2'b11;
         s_d.rn_s = 2'b11;
         s_d.prot = sfe_pkg::SFE_PROT_RST;
         s_d.plen = sfe_pkg::SFE_PAGE_STD;
      end
      if (prot_sw_en && !s_q.wp_latch && !wp_low && s_q.st == sfe_pkg::SFE_ST_IDLE && !rst)
      begin
         s_d.prot = prot_sw;
      end
      s_d.busy = (s_d.st == sfe_pkg::SFE_ST_BUSY);
      s_d.stby = (s_d.st == sfe_pkg::SFE_ST_IDLE);
   end

   always_ff @(posedge clk)
   begin
      s_q <= s_d;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign so = s_q.so;
   assign so_oe = s_q.so_oe;
   assign cmd_opcode = s_q.op;
   assign cmd_addr = s_q.addr;
   assign cmd_start = s_q.cmd_start;
   assign wr_data = buf_out_data;
   assign wr_valid = buf_out_valid;
   assign rd_take = s_q.rd_take;
   assign busy = s_q.busy;
   assign standby = s_q.stby;
   assign cmd_refused = s_q.refused;
   assign prot_table = s_q.prot;
   assign page_len = s_q.plen;
   assign overrun = s_q.overrun;

endmodule // sfe_front_end

// ### hdl/sfe_pkg.sv
// Package with the constants of the serial flash front end.
// Assumes one system clock of 125 MHz and a host-driven serial link.
//
// Overview of operation
// - Falling chip select starts an operation; rising chip select ends it.
// - Deselected with no program or erase running: device in standby, serial output released to high impedance.
// - Serial input is ignored entirely while chip select is high.
// - Input bits are sampled on each rising serial clock edge.
// - Output bit changes on each falling serial clock edge.
// - Program or erase cycle keeps running after deselect; standby follows its end.
// - Write-protect low shields every sector marked in the protection table.
// - While write-protect is low, and until the next idle after it rises, the protection table cannot be modified.
// - Protected program or erase is discarded; idle again at next deselect.
// - Serial clock mode 0 and mode 3 are both accepted.
// - Page length is 512 bytes by default, 528 with the option set.
// - First byte after select is the 8-bit opcode, then address bytes.
// - All bytes travel most significant bit first.
// - Reset aborts any operation and holds the machine idle.
package sfe_pkg;

   localparam int unsigned SFE_CLK_MHZ = 125;
   localparam int unsigned SFE_BUSY_US = 4;
   localparam int unsigned SFE_BUSY_CYC = SFE_BUSY_US * SFE_CLK_MHZ;
   localparam logic [7:0] SFE_OP_PROG = 8'h02;
   localparam logic [7:0] SFE_OP_ERASE = 8'h81;
   localparam logic [7:0] SFE_OP_PROT_WR = 8'h3D;
   localparam logic [7:0] SFE_OP_STATUS = 8'hD7;
   localparam int unsigned SFE_ADDR_BYTES = 3;
   localparam logic [9:0] SFE_PAGE_STD = 10'h200;
   localparam logic [9:0] SFE_PAGE_ALT = 10'h210;
   localparam int unsigned SFE_NUM_SECT = 16;
   localparam logic [15:0] SFE_PROT_RST = 16'h0000;

   typedef enum logic [2:0] {
      SFE_ST_IDLE,
      SFE_ST_OPCODE,
      SFE_ST_ADDR,
      SFE_ST_DATA,
      SFE_ST_IGNORE,
      SFE_ST_BUSY
   } sfe_state_t;

endpackage : sfe_pkg

// ### hdl/sfe_buf2.sv
// Two-entry valid/ready buffer for received bytes.
// Assumes both sides on the same clock.
`timescale 1ns/100ps
module sfe_buf2
(
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [7:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_data
);

   typedef struct packed {
      logic [1:0][7:0] mem;
      logic rd;
      logic wr;
      logic [1:0] cnt;
      logic out_v;
      logic [7:0] dout;
   } sfe_buf_t;

   sfe_buf_t s_q, s_d;

   always_comb
   begin
      logic push;
      logic pop;
      push = 1'b0;
      pop = 1'b0;
      s_d = s_q;
      push = in_valid && (s_q.cnt != 2'd2);
      pop = out_ready && (s_q.cnt != 2'd0);
      if (push)
      begin
         s_d.mem[s_q.wr] = in_data;
         s_d.wr = ~s_q.wr;
      end
      if (pop)
      begin
         s_d.rd = ~s_q.rd;
      end
      s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
      if (rst)
      begin
         s_d = '0;
      end
      // Output copies are taken from the next state, so they leave flip-flops with no extra cycle.
      s_d.out_v = (s_d.cnt != 2'd0);
      s_d.dout = s_d.mem[s_d.rd];
   end

   always_ff @(posedge clk)
   begin
      s_q <= s_d;
   end

   assign in_ready = (s_q.cnt != 2'd2);
   assign out_valid = s_q.out_v;
   assign out_data = s_q.dout;

endmodule // sfe_buf2

// ### sim/sfe_fe_monitor.sv
// Concurrent checks on the ports of the serial flash front end.
// Assumes one clk domain with rst synchronous and active high.
`timescale 1ns/100ps
module sfe_fe_monitor
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic so_oe,
   input wire logic wp_n,
   input wire logic reset_n,
   input wire logic page_alt,
   input wire logic cmd_start,
   input wire logic cmd_refused,
   input wire logic busy,
   input wire logic standby,
   input wire logic [15:0] prot_table,
   input wire logic [9:0] page_len
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic [9:0] run_q;
   logic [9:0] run_d;
   // Counts how long busy has stood so far.
   always_comb run_d = busy ? run_q + 10'h001 : 10'h000;
   always_ff @(posedge clk) run_q <= rst ? 10'h000 : run_d;
   sequence deselected_s;
      cs_n [*6];
   endsequence
   sequence start_s;
      cmd_start ##1 !cmd_start;
   endsequence
   so_release_a: assert property (deselected_s |-> !so_oe) else $error("so driven while deselected");
   busy_len_a: assert property ($fell(busy) |-> run_q == sfe_pkg::SFE_BUSY_CYC || !$past(reset_n, 2))
      else $error("busy length wrong");
   busy_standby_a: assert property (busy |-> !standby) else $error("standby while busy");
   start_busy_a: assert property (cmd_start |-> ##[1:2] busy) else $error("no busy after start");
   start_cs_a: assert property (cmd_start |-> $past(cs_n, 3) && !cmd_refused)
      else $error("start without deselect");
   start_pulse_a: assert property (cmd_start |-> start_s) else $error("start not a pulse");
   refuse_idle_a: assert property (cmd_refused |-> !busy) else $error("busy after refusal");
   page_alt_a: assert property (page_alt [*4] |-> page_len == sfe_pkg::SFE_PAGE_ALT)
      else $error("page not 528");
   page_std_a: assert property (!page_alt [*4] |-> page_len == sfe_pkg::SFE_PAGE_STD)
      else $error("page not 512");
   prot_lock_a: assert property (!wp_n [*6] |=> $stable(prot_table)) else $error("table changed");
   standby_idle_a: assert property (deselected_s ##0 !busy |-> standby)
      else $error("not in standby while deselected");
   abort_idle_a: assert property (!reset_n [*4] |-> standby && !busy)
      else $error("reset pin did not abort");
endmodule // sfe_fe_monitor

bind sfe_front_end sfe_fe_monitor mon (.clk, .rst, .cs_n, .so_oe, .wp_n, .reset_n, .page_alt, .cmd_start,
   .cmd_refused, .busy, .standby, .prot_table, .page_len);

// ### sim/sfe_host.sv
// Host model acting as SPI controller in mode 0 or mode 3.
// Assumes it is paced by clk; sck half period is five clk cycles, 40 ns.
`timescale 1ns/100ps
module sfe_host
(
   input wire logic clk,
   input wire logic so,
   output logic cs_n,
   output logic sck,
   output logic si
);
   logic mode3 = 1'b0;
   logic [7:0] rx8;
   initial
   begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // Serial input keeps changing while deselected, so a captured bit would show.
   task automatic gap(input int n);
      repeat (n)
      begin
         @(negedge clk);
         si = ~si;
      end
   endtask
   task automatic sel();
      @(negedge clk);
      sck = mode3;
      repeat (5) @(negedge clk);
      cs_n = 1'b0;
      repeat (5) @(negedge clk);
   endtask
   task automatic desel();
      repeat (5) @(negedge clk);
      sck = mode3;
      repeat (5) @(negedge clk);
      cs_n = 1'b1;
      repeat (5) @(negedge clk);
   endtask
   task automatic xfer(input logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--)
      begin
         sck = 1'b0;
         si = b[i];
         repeat (5) @(negedge clk);
         sck = 1'b1;
         r[i] = so;
         repeat (5) @(negedge clk);
      end
   endtask
   task automatic head(input logic [7:0] op, input logic [23:0] a);
      sel();
      xfer(op, rx8);
      for (int i = 2; i >= 0; i--)
         xfer(a[8 * i +: 8], rx8);
   endtask
endmodule // sfe_host

// ### sim/testbench.sv
// Self-checking bench of the serial flash front end.
// Assumes the host model drives the serial pins and the bench the rest.
`timescale 1ns/100ps
module testbench;
   logic clk = 1'b0;
   logic rst, wp_n, reset_n, page_alt, prot_sw_en, wr_ready;
   logic [15:0] prot_sw;
   logic [7:0] rd_byte;
   logic cs_n, sck, si, so, so_oe, cmd_start, wr_valid, rd_take, busy, standby, cmd_refused, overrun;
   logic [7:0] cmd_opcode, wr_data, r;
   logic [23:0] cmd_addr;
   logic [15:0] prot_table;
   logic [9:0] page_len;
   logic [7:0] dat [3] = '{8'h3C, 8'hC3, 8'h5A};
   logic [7:0] ops [3] = '{sfe_pkg::SFE_OP_PROG, sfe_pkg::SFE_OP_ERASE, sfe_pkg::SFE_OP_PROT_WR};
   int n_mismatch = 0;
   int comparisons = 0;
   int n_take = 0;
   int take0;
   always #4 clk = ~clk;
   always @(posedge clk)
      if (rd_take === 1'b1)
         n_take <= n_take + 1;
   sfe_host host (.clk, .so, .cs_n, .sck, .si);
   sfe_front_end dut (.clk, .rst, .cs_n, .sck, .si, .so, .so_oe, .wp_n, .reset_n, .page_alt, .prot_sw,
      .prot_sw_en, .cmd_opcode, .cmd_addr, .cmd_start, .wr_data, .wr_valid, .wr_ready, .rd_data(rd_byte),
      .rd_take, .busy, .standby, .cmd_refused, .prot_table, .page_len, .overrun);
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wait_idle(input int bound);
      int k;
      k = 0;
      while (busy !== 1'b0)
      begin
         @(negedge clk);
         k++;
         if (k > bound)
         begin
            n_mismatch++;
            $display("BAD %0t busy never ended", $time);
            close_out();
         end
      end
   endtask
   task automatic pop(input logic [7:0] e);
      chk(wr_valid, 1'b1, "wr_valid");
      chk(wr_data, e, "wr_data");
      wr_ready = 1'b1;
      @(negedge clk);
      wr_ready = 1'b0;
      @(negedge clk);
   endtask
   initial
   begin
      rst = 1'b1;
      wp_n = 1'b1;
      reset_n = 1'b1;
      page_alt = 1'b0;
      prot_sw_en = 1'b0;
      wr_ready = 1'b0;
      prot_sw = 16'h0000;
      rd_byte = 8'hA5;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      host.gap(2);
      chk(standby, 1'b1, "standby");
      chk(so_oe, 1'b0, "so_oe");
      chk(prot_table, sfe_pkg::SFE_PROT_RST, "table reset");
      page_alt = 1'b1;
      host.gap(6);
      chk(page_len, sfe_pkg::SFE_PAGE_ALT, "528 page");
      page_alt = 1'b0;
      host.gap(6);
      chk(page_len, sfe_pkg::SFE_PAGE_STD, "512 page");
      // Top of sector 0 with a stalled receiver; the third byte overruns.
      host.head(sfe_pkg::SFE_OP_PROG, 24'h01FFA5);
      foreach (dat[i])
         host.xfer(dat[i], r);
      host.desel();
      host.gap(2);
      chk(cmd_opcode, sfe_pkg::SFE_OP_PROG, "opcode");
      chk(cmd_addr, 24'h01FFA5, "address");
      chk(overrun, 1'b1, "overrun");
      chk(busy, 1'b1, "busy");
      chk(standby, 1'b0, "standby busy");
      pop(8'h3C);
      pop(8'hC3);
      chk(wr_valid, 1'b0, "drained");
      wait_idle(600);
      @(negedge clk);
      chk(standby, 1'b1, "standby done");
      prot_sw = 16'h0002;
      prot_sw_en = 1'b1;
      host.gap(6);
      chk(prot_table, 16'h0002, "table load");
      host.head(sfe_pkg::SFE_OP_ERASE, 24'h020000);
      host.desel();
      chk(cmd_refused, 1'b1, "sw refuse");
      chk(busy, 1'b0, "sw no busy");
      prot_sw_en = 1'b0;
      wp_n = 1'b0;
      foreach (ops[i])
      begin
         host.head(ops[i], 24'h03FFFF);
         host.xfer(8'h00, r);
         host.desel();
         host.gap(4);
         chk(busy, 1'b0, "wp no busy");
         chk(wr_valid, 1'b0, "wp no push");
         chk(standby, 1'b1, "wp idle");
         chk(prot_table, 16'h0002, "wp table");
         if (i < 2)
            chk(cmd_refused, 1'b1, "wp refuse");
      end
      prot_sw = 16'h0000;
      prot_sw_en = 1'b1;
      host.gap(6);
      chk(prot_table, 16'h0002, "wp load");
      prot_sw_en = 1'b0;
      wp_n = 1'b1;
      host.head(sfe_pkg::SFE_OP_ERASE, 24'h000000);
      host.desel();
      host.gap(4);
      chk(busy, 1'b1, "erase busy");
      reset_n = 1'b0;
      host.gap(10);
      chk(busy, 1'b0, "abort");
      chk(standby, 1'b1, "abort idle");
      reset_n = 1'b1;
      host.gap(6);
      take0 = n_take;
      for (int m = 0; m < 2; m++)
      begin
         host.mode3 = m[0];
         rd_byte = m[0] ? 8'h69 : 8'h96;
         host.head(sfe_pkg::SFE_OP_STATUS, 24'h000000);
         chk(so_oe, 1'b1, "so driven");
         host.xfer(8'h00, r);
         chk(r[7], 1'b1, "status ready");
         host.xfer(8'h00, r);
         chk(r, rd_byte, "read byte");
         host.desel();
      end
      chk(24'(n_take - take0), 24'h000004, "rd_take count");
      close_out();
   end
endmodule // testbench
